// >>> design/spcw_port.v
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "spcw_defines.vh"

// Overview of operation
// - A set direction bit tri-states that pin's driver, making it an input.
// - A cleared direction bit drives the pin from its output latch.
// - Pin 3 never drives; its direction bit always reads one.
// - Port reads return pin levels; writes load the latch with the written data.
// - With external reset enabled, pin 3 reads zero in the port register.
// - Analog-selected pins read zero, also inside read-modify-write.
// - Analog selection leaves the output driver path untouched.
// - Analog selection disables input buffer, pull-up and change detect.
// - Conversion clock field decodes to divide ratios or the RC clock.
// - Pins other than 3 have enabled pull-ups; bit 3 reads zero.
// - A pin configured as output has its pull-up switched off.
// - Pull-ups on pins other than 3 work only when globally allowed; disabled after power-on.
// - Pin 3 gets a pull-up only when acting as the external reset pin.
// - Crystal modes force direction bits 5:4 to one; RC/EXT force bit 5.
// - Crystal modes read change enables 5:4 zero, pull-ups 5:4 one.
// - Six change enable bits, all cleared by power-on reset.
// - Enabled mismatches against the last-read latch are ORed into the flag.
// - Flag keeps setting while mismatch persists; clear after port access.
// - Last-read latch survives external-pin and brown-out resets.
// - A change can wake from sleep; coincident port access may miss it.
// - Slow discharge enable turns on a current sink on pin 0.
// - Wake vectors to 0004h with global enable, else next instruction.
module spcw_port #(
    parameter NPINS = 6
) (
    // APB slave
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output wire              pready,
    output wire [31:0]       prdata,
    output wire              pslverr,
    // Reset causes and configuration
    input  wire              por_n,
    input  wire              ext_reset_pin_enable,
    input  wire [1:0]        osc_mode,
    input  wire              sleeping,
    // Pins
    input  wire [NPINS-1:0]  pin_level_bits,
    output wire [NPINS-1:0]  pin_out,
    output wire [NPINS-1:0]  pin_oe_n,
    output wire [NPINS-1:0]  pin_pullup_on,
    output wire [NPINS-1:0]  pin_input_buf_en,
    output wire              discharge_sink_on,
    // Core side
    output wire [3:0]        conv_clock_choice,
    output reg               port_change_flag,
    output wire              wake_request,
    output wire [15:0]       wake_vector,
    output wire              wake_to_vector
);
    reg  [NPINS-1:0] latch_ff;
    reg  [NPINS-1:0] dir_ff;
    reg  [6:0]       analog_select_ff;
    reg  [NPINS-1:0] pullup_ff;
    reg  [NPINS-1:0] chgen_ff;
    reg  [4:0]       ctrl_ff;
    reg  [NPINS-1:0] last_read_ff;
    reg              flag_ff;
    reg  [31:0]      rdata_ff;
    reg  [31:0]      nxt_rdata;
    reg  [NPINS-1:0] nxt_latch;
    reg  [3:0]       cclk;

    wire [NPINS-1:0] pins_sync;
    wire [NPINS-1:0] analog_mask;
    wire [NPINS-1:0] dir_eff;
    wire [NPINS-1:0] chgen_eff;
    wire [NPINS-1:0] pullup_rd;
    wire [NPINS-1:0] port_rd;
    wire [NPINS-1:0] mismatch;
    wire             xtal;
    wire             rcext;
    wire             wr_en;
    wire             rd_en;
    wire             port_access;
    wire             addr_ok;
    wire             pu_global;

    spcw_sync #(
        .WIDTH    (NPINS)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pin_level_bits),
        .sync_out (pins_sync)
    );

    assign xtal  = (osc_mode == `SPCW_OSC_XTAL);
    assign rcext = (osc_mode == `SPCW_OSC_RCEXT);

    // Analog pins are 0,1,2,4; pins 3 and 5 have no analog function
    assign analog_mask = {1'b0, analog_select_ff[3], 1'b0, analog_select_ff[2:0]};

    // Effective direction, forced by pin 3 and oscillator mode
    genvar i;
    generate
        for (i = 0; i < NPINS; i = i + 1) begin : g_pin
            if (i == `SPCW_PIN_INONLY) begin : g_in
                assign dir_eff[i] = 1'b1;
            end else if (i == 5) begin : g_b5
                assign dir_eff[i] = dir_ff[i] | xtal | rcext;
            end else if (i == 4) begin : g_b4
                assign dir_eff[i] = dir_ff[i] | xtal;
            end else begin : g_oth
                assign dir_eff[i] = dir_ff[i];
            end
            // Driver follows latch regardless of analog select
            assign pin_oe_n[i] = dir_eff[i];
            assign pin_out[i]  = latch_ff[i];
            assign pin_input_buf_en[i] = ~analog_mask[i];
            if (i == `SPCW_PIN_INONLY) begin : g_pu3
                assign pin_pullup_on[i] = ext_reset_pin_enable;
            end else begin : g_pux
                assign pin_pullup_on[i] = pu_global & pullup_rd[i] &
                    dir_eff[i] & ~analog_mask[i];
            end
        end
    endgenerate

    assign pu_global = ~ctrl_ff[`SPCW_CTRL_PU_DIS];
    assign pullup_rd = {pullup_ff[5:4] | {2{xtal}}, 1'b0,
                        pullup_ff[2:0]};
    assign chgen_eff = chgen_ff & {{2{~xtal}}, 4'hF};

    // Digital read value: analog pins and pin 3 as reset read zero
    assign port_rd = pins_sync & ~analog_mask &
        ~({{(NPINS-1){1'b0}}, ext_reset_pin_enable}
          << `SPCW_PIN_INONLY);

    assign mismatch = (port_rd ^ last_read_ff) & chgen_eff
        & ~analog_mask;

    assign discharge_sink_on = ctrl_ff[`SPCW_CTRL_ULP];

    always @* begin
        case (analog_select_ff[6:4])
            3'h0: cclk = `SPCW_CCLK_DIV2;
            3'h1: cclk = `SPCW_CCLK_DIV8;
            3'h2: cclk = `SPCW_CCLK_DIV32;
            3'h4: cclk = `SPCW_CCLK_DIV4;
            3'h5: cclk = `SPCW_CCLK_DIV16;
            3'h6: cclk = `SPCW_CCLK_DIV64;
            default: cclk = `SPCW_CCLK_RC;
        endcase
    end
    assign conv_clock_choice = cclk;

    // APB: zero wait state, error on unmapped address
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign addr_ok = (paddr[1:0] == 2'h0) &&
                     (paddr <= `SPCW_ADDR_STATUS);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = rdata_ff;
    assign port_access = psel & penable & addr_ok &&
                         (paddr == `SPCW_ADDR_PORT);

    // Address decode, one select per register
    wire             sel_port;
    wire             sel_dir;
    wire             sel_analog_select;
    wire             sel_pullup;
    wire             sel_chgen;
    wire             sel_ctrl;
    wire             sel_status;

    assign sel_port   = (paddr == `SPCW_ADDR_PORT);
    assign sel_dir    = (paddr == `SPCW_ADDR_DIR);
    assign sel_analog_select  = (paddr == `SPCW_ADDR_ANALOG_SELECT);
    assign sel_pullup = (paddr == `SPCW_ADDR_PULLUP);
    assign sel_chgen  = (paddr == `SPCW_ADDR_CHGEN);
    assign sel_ctrl   = (paddr == `SPCW_ADDR_CTRL);
    assign sel_status = (paddr == `SPCW_ADDR_STATUS);

    // Write strobes, live in the access cycle only
    wire             wr_port;
    wire             wr_dir;
    wire             wr_analog_select;
    wire             wr_pullup;
    wire             wr_chgen;
    wire             wr_ctrl;
    wire             wr_status;

    assign wr_port   = wr_en & sel_port;
    assign wr_dir    = wr_en & sel_dir;
    assign wr_analog_select  = wr_en & sel_analog_select;
    assign wr_pullup = wr_en & sel_pullup;
    assign wr_chgen  = wr_en & sel_chgen;
    assign wr_ctrl   = wr_en & sel_ctrl;
    assign wr_status = wr_en & sel_status;

    // Read words, zero-extended to the bus width
    wire [31:0]      rword_port;
    wire [31:0]      rword_dir;
    wire [31:0]      rword_analog_select;
    wire [31:0]      rword_pullup;
    wire [31:0]      rword_chgen;
    wire [31:0]      rword_ctrl;
    wire [31:0]      rword_status;

    assign rword_port   = {{26{1'b0}}, port_rd};
    assign rword_dir    = {{26{1'b0}}, dir_eff};
    assign rword_analog_select  = {{25{1'b0}}, analog_select_ff};
    assign rword_pullup = {{26{1'b0}}, pullup_rd};
    assign rword_chgen  = {{26{1'b0}}, chgen_eff};
    assign rword_ctrl   = {{29{1'b0}}, ctrl_ff[2:0]};
    assign rword_status = {{31{1'b0}}, flag_ff};

    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (paddr)
            `SPCW_ADDR_PORT:   nxt_rdata = rword_port;
            `SPCW_ADDR_DIR:    nxt_rdata = rword_dir;
            `SPCW_ADDR_ANALOG_SELECT:  nxt_rdata = rword_analog_select;
            `SPCW_ADDR_PULLUP: nxt_rdata = rword_pullup;
            `SPCW_ADDR_CHGEN:  nxt_rdata = rword_chgen;
            `SPCW_ADDR_CTRL:   nxt_rdata = rword_ctrl;
            `SPCW_ADDR_STATUS: nxt_rdata = rword_status;
            default:           nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Read-modify-write: a full-port write replaces every bit
    always @* begin
        nxt_latch = latch_ff;
        if (wr_port)
            nxt_latch = pwdata[5:0] | (port_rd & 6'h00);
    end

    // Read data is registered in the setup cycle, so it is valid by access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Output latch, cleared by every reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_ff <= 6'h00;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    // Direction; bit 3 is stored as one so no path can ever drive it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_ff <= `SPCW_RST_DIR;
        end else if (wr_dir) begin
            dir_ff <= pwdata[5:0] | 6'h08;
        end
    end

    // Analog select and conversion clock field
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_select_ff <= `SPCW_RST_ANALOG_SELECT;
        end else if (wr_analog_select) begin
            analog_select_ff <= pwdata[6:0];
        end
    end

    // Pull-up enables; bit 3 has no pull-up and stores zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_ff <= `SPCW_RST_PULLUP;
        end else if (wr_pullup) begin
            pullup_ff <= pwdata[5:0] & 6'h37;
        end
    end

    // Set beats clear, so a clear issued while a mismatch remains is
    // lost; a port access in flight suppresses the set, which is allowed
    reg              nxt_flag;
    always @* begin
        nxt_flag = flag_ff;
        if (wr_status && pwdata[0])
            nxt_flag = 1'b0;
        if (|mismatch && !port_access)
            nxt_flag = 1'b1;
    end

    // Change flag, cleared by every reset and set again by a mismatch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // Change enables survive external and brown-out resets
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            chgen_ff <= `SPCW_RST_CHGEN;
        end else if (wr_chgen) begin
            chgen_ff <= pwdata[5:0];
        end
    end

    // Control; upper bits are reserved and always store zero
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            ctrl_ff <= `SPCW_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_ff <= {2'b00, pwdata[2:0]};
        end
    end

    // The last-read latch sits on power-on reset only, so a mismatch
    // pending across an external or brown-out reset sets the flag again
    always @(posedge pclk or negedge por_n) begin
        if (!por_n) begin
            last_read_ff <= 6'h00;
        end else if (port_access) begin
            last_read_ff <= port_rd;
        end
    end

    always @* begin
        port_change_flag = flag_ff;
    end

    // Wake is level based: it stays up until software clears the flag
    assign wake_request   = sleeping & flag_ff;
    assign wake_to_vector = ctrl_ff[`SPCW_CTRL_GIE];
    assign wake_vector    = `SPCW_IRQ_VECTOR;
endmodule

// >>> design/spcw_defines.vh
`ifndef SPCW_DEFINES_VH
`define SPCW_DEFINES_VH

// Register byte addresses on APB
`define SPCW_ADDR_PORT        12'h000
`define SPCW_ADDR_DIR         12'h004
`define SPCW_ADDR_ANALOG_SELECT       12'h008
`define SPCW_ADDR_PULLUP      12'h00C
`define SPCW_ADDR_CHGEN       12'h010
`define SPCW_ADDR_CTRL        12'h014
`define SPCW_ADDR_STATUS      12'h018

// Reset values
`define SPCW_RST_DIR          6'h3F
`define SPCW_RST_ANALOG_SELECT        7'h0F
`define SPCW_RST_PULLUP       6'h37
`define SPCW_RST_CHGEN        6'h00
`define SPCW_RST_CTRL         5'h01

// Control register fields
`define SPCW_CTRL_PU_DIS      0
`define SPCW_CTRL_GIE         1
`define SPCW_CTRL_ULP         2
`define SPCW_CTRL_FLAG_CLR    3

// Oscillator modes
`define SPCW_OSC_INTOSC       2'h0
`define SPCW_OSC_XTAL         2'h1
`define SPCW_OSC_RCEXT        2'h2

// Bit positions
`define SPCW_PIN_INONLY       3
`define SPCW_NPINS            6

// Conversion clock choices
`define SPCW_CCLK_DIV2        4'h0
`define SPCW_CCLK_DIV8        4'h1
`define SPCW_CCLK_DIV32       4'h2
`define SPCW_CCLK_DIV4        4'h3
`define SPCW_CCLK_DIV16       4'h4
`define SPCW_CCLK_DIV64       4'h5
`define SPCW_CCLK_RC          4'h6

// Wake vectors
`define SPCW_IRQ_VECTOR       16'h0004

`endif

// >>> design/spcw_sync.v
`timescale 1ns/1ps
module spcw_sync #(
    parameter WIDTH = 6
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_ff;
    reg [WIDTH-1:0] stage2_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_ff <= {WIDTH{1'b0}};
            stage2_ff <= {WIDTH{1'b0}};
        end else begin
            stage1_ff <= async_in;
            stage2_ff <= stage1_ff;
        end
    end

    assign sync_out = stage2_ff;
endmodule

// >>> testbench/spcw_asserts.sv
`timescale 1ns/1ps
module spcw_asserts (
    // APB
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    // Configuration
    input wire        ext_reset_pin_enable,
    input wire [1:0]  osc_mode,
    input wire        sleeping,
    // Pins and core side
    input wire [5:0]  pin_out,
    input wire [5:0]  pin_oe_n,
    input wire [5:0]  pin_pullup_on,
    input wire        port_change_flag,
    input wire        wake_request,
    input wire [15:0] wake_vector
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rdp = psel && penable && !pwrite;
    wire wrp = psel && penable && pwrite;

    a_in_only_pin: assert property (pin_oe_n[3])
        else $error("input only pin driven");
    a_pullup_out_off: assert property ((~pin_oe_n & pin_pullup_on) == 6'h00)
        else $error("pull-up on an output");
    // Pull-up follows the reset-pin mode once the mode has settled
    a_reset_pin_pu: assert property ($stable(ext_reset_pin_enable)[*2]
        |-> pin_pullup_on[3] == ext_reset_pin_enable)
        else $error("reset pin pull-up wrong");
    a_port_write: assert property (wrp && paddr == 12'h000
        |=> {26'h0, pin_out} == ($past(pwdata) & 32'h3F))
        else $error("port latch not loaded");
    a_rd_pin3_zero: assert property (rdp && paddr == 12'h000
        && ext_reset_pin_enable |-> !prdata[3])
        else $error("pin 3 read not zero");
    a_dir3_reads_one: assert property (rdp && paddr == 12'h004 |-> prdata[3])
        else $error("direction bit 3 not one");
    a_dir_xtal: assert property (rdp && paddr == 12'h004 && osc_mode == 2'h1
        |-> prdata[5:4] == 2'h3)
        else $error("crystal direction bits");
    a_chg_xtal: assert property (rdp && paddr == 12'h010 && osc_mode == 2'h1
        |-> prdata[5:4] == 2'h0)
        else $error("crystal change enables");
    a_flag_clear: assert property ($fell(port_change_flag)
        |-> $past(wrp && paddr == 12'h018 && pwdata[0]))
        else $error("flag fell without clear");
    a_wake_req: assert property (wake_request == (sleeping && port_change_flag))
        else $error("wake request wrong");
    a_wake_vec: assert property (wake_vector == 16'h0004)
        else $error("wake vector wrong");

    cover property (port_change_flag && sleeping);
    cover property (rdp && paddr == 12'h000 && ext_reset_pin_enable);
    cover property (wrp && paddr == 12'h018);
endmodule

// >>> testbench/spcw_board.sv
`timescale 1ns/1ps
module spcw_board (
    // Clock
    input  wire        pclk,
    // Device drive
    input  wire [5:0]  pin_out,
    input  wire [5:0]  pin_oe_n,
    input  wire [5:0]  pin_pullup_on,
    // Board drive
    input  wire [5:0]  drv_en,
    input  wire [5:0]  drv_val,
    // Levels at the pins
    output logic [5:0] pin_level_bits
);
    logic [5:0] flt_ff = 6'h15;

    // Floating pins wander so a stale value never passes for a level
    always @(posedge pclk) flt_ff <= ~flt_ff;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!pin_oe_n[i])
                pin_level_bits[i] = pin_out[i];
            else if (drv_en[i])
                pin_level_bits[i] = drv_val[i];
            else if (pin_pullup_on[i])
                pin_level_bits[i] = 1'h1;
            else
                pin_level_bits[i] = flt_ff[i];
        end
    end
endmodule

// >>> testbench/tb_six_bit_port_with_change_wakeup.sv
`timescale 1ns/1ps
module tb_six_bit_port_with_change_wakeup;
    logic        pclk = '0, presetn = '0, por_n = '0, sleeping = '0;
    logic        psel = '0, penable = '0, pwrite = '0, err;
    logic        ext_reset_pin_enable = '0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, got;
    logic [1:0]  osc_mode = '0;
    logic [5:0]  drv_en = '0, drv_val = '0;
    int          n_mismatch = 0, num_checks = 0, cyc = 0;
    wire         pready, pslverr, discharge_sink_on, port_change_flag;
    wire         wake_request, wake_to_vector;
    wire  [31:0] prdata;
    wire  [5:0]  pin_level_bits, pin_out, pin_oe_n, pin_pullup_on;
    wire  [5:0]  pin_input_buf_en;
    wire  [3:0]  conv_clock_choice;
    wire  [15:0] wake_vector;
    localparam logic [31:0] CCK = 32'h65436210;

    spcw_port uut (.*);
    spcw_board board (.*);

    always #25 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(string nm, logic [31:0] g, logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask

    // Holds the request until pready is seen high at an edge
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        got = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d);
        xfer(1'h1, a, d);
    endtask

    task automatic rd(logic [11:0] a, logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        chk("prdata", got, e);
    endtask

    task automatic w4();
        repeat (4) @(posedge pclk);
        #1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        por_n <= 1'h1;
        rd(12'h004, 32'h3F);
        rd(12'h008, 32'h0F);
        rd(12'h00C, 32'h37);
        rd(12'h010, 32'h00);
        chk("pullup", pin_pullup_on, 6'h00);
        wr(12'h008, 32'h0);
        wr(12'h014, 32'h0);
        chk("pullup", pin_pullup_on, 6'h37);
        @(posedge pclk) ext_reset_pin_enable <= 1'h1;
        w4();
        chk("pullup", pin_pullup_on, 6'h3F);
        wr(12'h004, 32'h0);
        chk("oe_n", pin_oe_n, 6'h08);
        chk("pullup", pin_pullup_on, 6'h08);
        rd(12'h004, 32'h08);
        wr(12'h000, 32'h15);
        chk("pin_out", pin_out, 6'h15);
        @(posedge pclk);
        drv_en <= 6'h08;
        drv_val <= 6'h08;
        w4();
        rd(12'h000, 32'h15);
        @(posedge pclk) ext_reset_pin_enable <= 1'h0;
        w4();
        rd(12'h000, 32'h1D);
        wr(12'h008, 32'h0F);
        chk("oe_n", pin_oe_n, 6'h08);
        chk("pin_out", pin_out, 6'h15);
        chk("buf_en", pin_input_buf_en, 6'h28);
        w4();
        rd(12'h000, 32'h08);
        wr(12'h004, 32'h3F);
        chk("pullup", pin_pullup_on, 6'h20);
        for (int i = 0; i < 8; i++) begin
            wr(12'h008, i << 4);
            chk("conv", conv_clock_choice, CCK[i*4 +: 4]);
        end
        wr(12'h004, 32'h0);
        @(posedge pclk) osc_mode <= 2'h1;
        rd(12'h004, 32'h38);
        wr(12'h010, 32'h3F);
        rd(12'h010, 32'h0F);
        wr(12'h00C, 32'h0);
        rd(12'h00C, 32'h30);
        @(posedge pclk) osc_mode <= 2'h2;
        rd(12'h004, 32'h28);
        @(posedge pclk) osc_mode <= 2'h0;
        wr(12'h004, 32'h3F);
        @(posedge pclk);
        drv_en <= 6'h3F;
        drv_val <= 6'h00;
        wr(12'h010, 32'h20);
        w4();
        rd(12'h000, 32'h00);
        wr(12'h018, 32'h1);
        chk("flag", port_change_flag, 1'h0);
        @(posedge pclk) drv_val <= 6'h02;
        w4();
        chk("flag", port_change_flag, 1'h0);
        @(posedge pclk);
        drv_val <= 6'h22;
        sleeping <= 1'h1;
        w4();
        chk("flag", port_change_flag, 1'h1);
        chk("wake", wake_request, 1'h1);
        wr(12'h014, 32'h2);
        chk("to_vec", wake_to_vector, 1'h1);
        wr(12'h018, 32'h1);
        chk("flag", port_change_flag, 1'h1);
        @(posedge pclk) presetn <= 1'h0;
        @(posedge pclk) presetn <= 1'h1;
        w4();
        chk("flag", port_change_flag, 1'h1);
        rd(12'h010, 32'h20);
        rd(12'h000, 32'h20);
        wr(12'h018, 32'h1);
        chk("flag", port_change_flag, 1'h0);
        wr(12'h014, 32'h4);
        chk("sink", discharge_sink_on, 1'h1);
        rd(12'h01C, 32'h0);
        chk("pslverr", err, 1'h1);
        results();
    end
endmodule

bind spcw_port spcw_asserts chk_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .ext_reset_pin_enable, .osc_mode,
    .sleeping, .pin_out, .pin_oe_n, .pin_pullup_on, .port_change_flag,
    .wake_request, .wake_vector);
